// ---- rtl/mcx_consts.svh ----
// Register offsets, field widths, reset values and cycle counts of the execution unit.
`ifndef MCX_CONSTS_SVH
`define MCX_CONSTS_SVH
`define MCX_A_INSTR   8'h00
`define MCX_A_STATUS  8'h04
`define MCX_A_ACC     8'h08
`define MCX_A_FLAGS   8'h0c
`define MCX_A_PC_LO   8'h10
`define MCX_A_TAB_PTR 8'h14
`define MCX_A_TAB_HI  8'h18
`define MCX_A_MADDR   8'h1c
`define MCX_A_MDATA   8'h20
`define MCX_INSTR_W   26
`define MCX_ADDR_W    9
`define MCX_PC_LO_ADDR 9'h006
`define MCX_LAST_PAGE 8'hff
`define MCX_RST_BYTE  8'h00
`define MCX_CYC_ONE   3'h1
`define MCX_CYC_TWO   3'h2
`define MCX_CYC_THREE 3'h3
`define MCX_CYC_FOUR  3'h4
`define MCX_BCD_ADJ   4'h6
`define MCX_BCD_MAX   4'h9
`endif

// ---- rtl/mcx_pkg.sv ----
// Types shared by the execution unit: opcodes, instruction word, flags and state.
`include "mcx_consts.svh"
package mcx_pkg;
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADC = 6'h01, OP_SUB = 6'h02, OP_SBC = 6'h03, OP_DAA = 6'h04,
    OP_AND = 6'h05, OP_OR = 6'h06, OP_XOR = 6'h07, OP_CPL = 6'h08, OP_INC = 6'h09,
    OP_DEC = 6'h0a, OP_RR = 6'h0b, OP_RRC = 6'h0c, OP_RL = 6'h0d, OP_RLC = 6'h0e,
    OP_MOV = 6'h0f, OP_CLRB = 6'h10, OP_SETB = 6'h11, OP_SZ = 6'h12, OP_SNZ = 6'h13,
    OP_SZB = 6'h14, OP_SNZB = 6'h15, OP_SIZ = 6'h16, OP_SDZ = 6'h17, OP_TAB = 6'h18,
    OP_CLRM = 6'h19, OP_SETM = 6'h1a, OP_SWAP = 6'h1b, OP_CLRWDT = 6'h1c,
    OP_HALT = 6'h1d, OP_NOP = 6'h1e
  } mcx_op_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} mcx_fsm_t;
  typedef struct packed {
    logic [`MCX_ADDR_W-1:0] addr;
    logic [7:0]             imm;
    logic                   use_imm;
    logic                   to_mem;
    logic                   ext;
    mcx_op_t                op;
  } mcx_instr_t;
  typedef struct packed {
    logic pdn; logic to; logic czero; logic sgn; logic ovf; logic c; logic hc; logic z;
  } mcx_flags_t;
  typedef struct packed {
    mcx_fsm_t               fsm;
    logic [2:0]             cnt;
    mcx_instr_t             ins;
    logic [7:0]             acc;
    mcx_flags_t             fl;
    logic [7:0]             pc_lo;
    logic [7:0]             tab_ptr;
    logic [7:0]             page;
    logic [7:0]             tab_hi;
    logic [15:0]            pma;
    logic [31:0]            prd;
    logic                   done;
    logic                   halt;
    logic [2:0]             last_cyc;
    logic                   last_skip;
    logic [`MCX_ADDR_W-1:0] maddr;
  } mcx_state_t;
endpackage

// ---- rtl/mcx_exec.sv ----
// Execution unit of an 8-bit core: timing, flags and data memory, with an APB register port.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mcx_consts.svh"
module mcx_exec #(
  parameter int unsigned DM_DEPTH = 512
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory for table reads, data valid one cycle after the address.
  output logic      [15:0] pmem_addr,
  input  wire logic [15:0] pmem_rdata,
  // Watchdog and status.
  input  wire logic        wdt_timeout_evt,
  output logic             busy,
  output logic             instr_done,
  output logic             halt_req
);
  mcx_pkg::mcx_state_t       s_q;
  mcx_pkg::mcx_state_t       s_d;
  mcx_pkg::mcx_instr_t       cur;
  logic [7:0]                mem [DM_DEPTH];
  logic [`MCX_ADDR_W-1:0]    ea;
  logic [7:0]                mval;
  logic [7:0]                opa;
  logic [7:0]                opb;
  logic [7:0]                res;
  logic [8:0]                sum;
  logic [4:0]                half;
  logic                      cin;
  logic                      wr_acc;
  logic                      wr_mem;
  logic                      skip;
  logic                      pc_lo_wr;
  logic                      is_tab;
  logic [2:0]                cyc;
  mcx_pkg::mcx_flags_t       nfl;
  logic                      hit;
  logic                      err;
  logic                      we;
  logic                      issue;
  logic                      fin;
  logic                      mw_en;
  logic [`MCX_ADDR_W-1:0]    mw_addr;
  logic [7:0]                mw_data;
  logic [7:0]                pg;
  logic [7:0]                tp;

  // Bus decode; a write while busy is refused so memory and accumulator hold during a run.
  always_comb
  begin
    unique case (paddr)
      `MCX_A_INSTR, `MCX_A_STATUS, `MCX_A_ACC, `MCX_A_FLAGS, `MCX_A_PC_LO,
      `MCX_A_TAB_PTR, `MCX_A_TAB_HI, `MCX_A_MADDR, `MCX_A_MDATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign err     = ~hit | (pwrite & (s_q.fsm == mcx_pkg::ST_EXEC));
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err;
  assign we      = psel & penable & pwrite & ~err;
  assign issue   = we & (paddr == `MCX_A_INSTR);
  assign fin     = (s_q.fsm == mcx_pkg::ST_EXEC) && (s_q.cnt == 3'h0);

  // Execution datapath, evaluated on the issuing word and again on the held one at commit.
  always_comb
  begin
    cur    = issue ? mcx_pkg::mcx_instr_t'(pwdata[`MCX_INSTR_W-1:0]) : s_q.ins;
    ea     = cur.ext ? cur.addr : {1'b0, cur.addr[7:0]};
    mval   = (ea == `MCX_PC_LO_ADDR) ? s_q.pc_lo : mem[ea];
    opa    = s_q.acc;
    opb    = cur.use_imm ? cur.imm : mval;
    cin    = 1'b0;
    res    = mval;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    skip   = 1'b0;
    is_tab = 1'b0;
    nfl    = s_q.fl;
    // Subtraction reuses the adder: add the complement, carry means no borrow.
    if (cur.op == mcx_pkg::OP_SUB || cur.op == mcx_pkg::OP_SBC)
      opb = ~opb;
    if (cur.op == mcx_pkg::OP_ADC || cur.op == mcx_pkg::OP_SBC)
      cin = s_q.fl.c;
    else if (cur.op == mcx_pkg::OP_SUB)
      cin = 1'b1;
    if (cur.op == mcx_pkg::OP_DAA)
    begin
      opb = {((opa[7:4] > `MCX_BCD_MAX) || s_q.fl.c) ? `MCX_BCD_ADJ : 4'h0,
             ((opa[3:0] > `MCX_BCD_MAX) || s_q.fl.hc) ? `MCX_BCD_ADJ : 4'h0};
    end
    sum  = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    half = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    case (cur.op)
      mcx_pkg::OP_ADD, mcx_pkg::OP_ADC, mcx_pkg::OP_SUB, mcx_pkg::OP_SBC:
      begin
        res    = sum[7:0];
        nfl.z  = (sum[7:0] == 8'h00);
        nfl.c  = sum[8];
        nfl.hc = half[4];
        nfl.ovf = (opa[7] == opb[7]) && (sum[7] != opa[7]);
        nfl.sgn = nfl.ovf ^ sum[7];
        if (cur.op == mcx_pkg::OP_SUB)
          nfl.czero = nfl.z;
        else if (cur.op == mcx_pkg::OP_SBC)
          nfl.czero = nfl.z & s_q.fl.z;
      end
      mcx_pkg::OP_DAA:
      begin
        res    = sum[7:0];
        wr_mem = 1'b1;
        nfl.c  = sum[8] | s_q.fl.c;
      end
      mcx_pkg::OP_AND: res = opa & opb;
      mcx_pkg::OP_OR:  res = opa | opb;
      mcx_pkg::OP_XOR: res = opa ^ opb;
      mcx_pkg::OP_CPL: res = ~mval;
      mcx_pkg::OP_INC: res = mval + 8'h01;
      mcx_pkg::OP_DEC: res = mval - 8'h01;
      mcx_pkg::OP_RR:  res = {mval[0], mval[7:1]};
      mcx_pkg::OP_RL:  res = {mval[6:0], mval[7]};
      mcx_pkg::OP_RRC:
      begin
        res   = {s_q.fl.c, mval[7:1]};
        nfl.c = mval[0];
      end
      mcx_pkg::OP_RLC:
      begin
        res   = {mval[6:0], s_q.fl.c};
        nfl.c = mval[7];
      end
      mcx_pkg::OP_MOV:  res = cur.to_mem ? opa : opb;
      mcx_pkg::OP_CLRB: res = mval & ~(8'h01 << cur.imm[2:0]);
      mcx_pkg::OP_SETB: res = mval | (8'h01 << cur.imm[2:0]);
      mcx_pkg::OP_CLRM: res = 8'h00;
      mcx_pkg::OP_SETM: res = 8'hff;
      mcx_pkg::OP_SWAP: res = {mval[3:0], mval[7:4]};
      mcx_pkg::OP_SIZ:  res = mval + 8'h01;
      mcx_pkg::OP_SDZ:  res = mval - 8'h01;
      default:          res = mval;
    endcase
    // Zero-only flag group; the wider groups set their own flags above.
    if (cur.op inside {mcx_pkg::OP_AND, mcx_pkg::OP_OR, mcx_pkg::OP_XOR, mcx_pkg::OP_CPL,
                       mcx_pkg::OP_INC, mcx_pkg::OP_DEC})
      nfl.z = (res == 8'h00);
    // Destination and skip test.
    case (cur.op)
      mcx_pkg::OP_DAA, mcx_pkg::OP_CLRB, mcx_pkg::OP_SETB, mcx_pkg::OP_CLRM,
      mcx_pkg::OP_SETM: wr_mem = 1'b1;
      mcx_pkg::OP_SZ:   skip = (mval == 8'h00);
      mcx_pkg::OP_SNZ:  skip = (mval != 8'h00);
      mcx_pkg::OP_SZB:  skip = ~mval[cur.imm[2:0]];
      mcx_pkg::OP_SNZB: skip = mval[cur.imm[2:0]];
      mcx_pkg::OP_SIZ, mcx_pkg::OP_SDZ:
      begin
        skip   = (res == 8'h00);
        wr_mem = cur.to_mem;
        wr_acc = ~cur.to_mem;
      end
      mcx_pkg::OP_TAB: is_tab = 1'b1;
      mcx_pkg::OP_CLRWDT, mcx_pkg::OP_HALT, mcx_pkg::OP_NOP: wr_acc = 1'b0;
      default:
      begin
        wr_mem = cur.to_mem & ~cur.use_imm;
        wr_acc = ~cur.to_mem | cur.use_imm;
      end
    endcase
    // The SZ skip with to_mem clear also moves the byte to the accumulator.
    if ((cur.op == mcx_pkg::OP_SZ) && !cur.to_mem)
    begin
      wr_acc = 1'b1;
      res    = mval;
    end
    pc_lo_wr = wr_mem && (ea == `MCX_PC_LO_ADDR);
    // Cycle count: the skip penalty covers the discarded next word.
    cyc = cur.ext ? `MCX_CYC_TWO : `MCX_CYC_ONE;
    if (is_tab)
      cyc = cur.ext ? `MCX_CYC_THREE : `MCX_CYC_TWO;
    if (pc_lo_wr)
      cyc = cur.ext ? `MCX_CYC_THREE : `MCX_CYC_TWO;
    if (skip)
      cyc = cur.ext ? `MCX_CYC_FOUR : `MCX_CYC_THREE;
    // Table address, pre-incremented pointer and last-page selection.
    tp = cur.imm[1] ? s_q.tab_ptr + 8'h01 : s_q.tab_ptr;
    pg = cur.imm[0] ? `MCX_LAST_PAGE : s_q.page;
  end

  // Memory write port: the commit of an instruction or a software access.
  always_comb
  begin
    mw_en   = 1'b0;
    mw_addr = ea;
    mw_data = res;
    if (fin && is_tab)
    begin
      mw_en   = (ea != `MCX_PC_LO_ADDR);
      mw_data = pmem_rdata[7:0];
    end
    else if (fin && wr_mem && !pc_lo_wr)
      mw_en = 1'b1;
    else if (we && (paddr == `MCX_A_MDATA))
    begin
      mw_en   = 1'b1;
      mw_addr = s_q.maddr;
      mw_data = pwdata[7:0];
    end
  end

  // Next state of the control, register file and read data.
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.halt = 1'b0;
    if (issue)
    begin
      s_d.ins = cur;
      s_d.fsm = mcx_pkg::ST_EXEC;
      s_d.cnt = cyc - 3'h1;
      s_d.pma = {pg, tp};
    end
    else if (s_q.fsm == mcx_pkg::ST_EXEC && !fin)
      s_d.cnt = s_q.cnt - 3'h1;
    if (fin)
    begin
      s_d.fsm       = mcx_pkg::ST_IDLE;
      s_d.done      = 1'b1;
      s_d.last_cyc  = cyc;
      s_d.last_skip = skip;
      s_d.fl        = nfl;
      if (wr_acc)
        s_d.acc = res;
      s_d.pc_lo = pc_lo_wr ? res : s_q.pc_lo + (skip ? 8'h02 : 8'h01);
      if (is_tab)
      begin
        s_d.tab_ptr = tp;
        s_d.tab_hi  = pmem_rdata[15:8];
      end
      if (cur.op == mcx_pkg::OP_CLRWDT)
      begin
        s_d.fl.to  = 1'b0;
        s_d.fl.pdn = 1'b0;
      end
      if (cur.op == mcx_pkg::OP_HALT)
      begin
        s_d.fl.to  = 1'b0;
        s_d.fl.pdn = 1'b1;
        s_d.halt   = 1'b1;
      end
    end
    // Software register writes.
    if (we)
    begin
      case (paddr)
        `MCX_A_ACC:   s_d.acc = pwdata[7:0];
        `MCX_A_FLAGS: s_d.fl = mcx_pkg::mcx_flags_t'(pwdata[7:0]);
        `MCX_A_PC_LO:   s_d.pc_lo = pwdata[7:0];
        `MCX_A_TAB_PTR: {s_d.page, s_d.tab_ptr} = pwdata[15:0];
        `MCX_A_MADDR: s_d.maddr = pwdata[`MCX_ADDR_W-1:0];
        default:      s_d.maddr = s_d.maddr;
      endcase
    end
    // A timeout arriving with a clear still sets the flag.
    if (wdt_timeout_evt)
      s_d.fl.to = 1'b1;
    // Read data is captured in the setup phase so the access phase sees a register.
    if (psel && !penable)
    begin
      case (paddr)
        `MCX_A_INSTR:  s_d.prd = {6'h00, s_q.ins};
        `MCX_A_STATUS: s_d.prd = {27'h0, s_q.last_skip, s_q.last_cyc, s_q.fsm};
        `MCX_A_ACC:    s_d.prd = {24'h0, s_q.acc};
        `MCX_A_FLAGS:  s_d.prd = {24'h0, s_q.fl};
        `MCX_A_PC_LO:   s_d.prd = {24'h0, s_q.pc_lo};
        `MCX_A_TAB_PTR: s_d.prd = {16'h0, s_q.page, s_q.tab_ptr};
        `MCX_A_TAB_HI:  s_d.prd = {24'h0, s_q.tab_hi};
        `MCX_A_MADDR:  s_d.prd = {23'h0, s_q.maddr};
        `MCX_A_MDATA:  s_d.prd = {24'h0, mem[s_q.maddr]};
        default:       s_d.prd = 32'h0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Data memory has no reset; software initialises what it uses.
  always_ff @(posedge pclk)
  begin
    if (mw_en)
      mem[mw_addr] <= mw_data;
  end

  assign prdata     = s_q.prd;
  assign pmem_addr  = s_q.pma;
  assign busy       = (s_q.fsm == mcx_pkg::ST_EXEC);
  assign instr_done = s_q.done;
  assign halt_req   = s_q.halt;

  // Helper: cycles already spent in the current run.
  logic [2:0] run_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_q <= 3'h0;
    else
      run_q <= (busy && !fin) ? run_q + 3'h1 : 3'h0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  basic_skip_a: assert property (fin && !cur.ext && skip |-> run_q == 3'h2)
    else $error("basic skip not three cycles");
  basic_pcw_a: assert property (fin && !cur.ext && pc_lo_wr && !skip |-> run_q == 3'h1)
    else $error("basic PC low write not two cycles");
  wdt_clear_a: assert property (fin && cur.op == mcx_pkg::OP_CLRWDT && !wdt_timeout_evt
                                |=> !s_q.fl.to && !s_q.fl.pdn)
    else $error("watchdog clear left flags set");
  ext_plain_a: assert property (fin && cur.ext && !skip && !is_tab && !pc_lo_wr
                                |-> run_q == 3'h1)
    else $error("extended instruction not two cycles");
  logic_flags_a: assert property (fin && cur.op inside {mcx_pkg::OP_AND, mcx_pkg::OP_OR}
                                  |=> $stable({s_q.fl.c, s_q.fl.hc, s_q.fl.ovf, s_q.fl.sgn}))
    else $error("logic op changed arithmetic flags");
  ext_table_a: assert property (fin && cur.ext && is_tab && !pc_lo_wr
                                |-> run_q == 3'h2 ##1 s_q.tab_hi == $past(pmem_rdata[15:8]))
    else $error("extended table read timing or latch wrong");
  ext_skip_a: assert property (fin && cur.ext && skip |-> run_q == 3'h3)
    else $error("extended skip not four cycles");
  ext_pcw_a: assert property (fin && cur.ext && pc_lo_wr && !skip |-> run_q == 3'h2)
    else $error("extended PC low write not three cycles");
  zero_flag_a: assert property (fin && wr_acc && cur.op inside {mcx_pkg::OP_ADD,
                                mcx_pkg::OP_AND} |=> s_q.fl.z == (s_q.acc == 8'h00))
    else $error("zero flag disagrees with result");
  sector_a: assert property (issue && !cur.ext |-> ea[`MCX_ADDR_W-1] == 1'b0)
    else $error("basic instruction left sector zero");

  skip_taken_c: cover property (fin && skip && cur.ext);
  table_read_c: cover property (fin && is_tab);
  pc_write_c:   cover property (fin && pc_lo_wr);
endmodule // mcx_exec
`default_nettype wire

// ---- tb/mcx_pmem_model.sv ----
// Program memory model that answers table reads of the execution unit.
`timescale 1ns/1ps
`default_nettype none
module mcx_pmem_model #(
  parameter logic [15:0] PATTERN = 16'ha5c3
) (
  // Clock.
  input  wire logic        pclk,
  // Table read port.
  input  wire logic [15:0] pmem_addr,
  output logic      [15:0] pmem_rdata
);
  // The word follows its address by one cycle, as a synchronous array would deliver it.
  always_ff @(posedge pclk)
  begin
    pmem_rdata <= pmem_addr ^ PATTERN;
  end
endmodule // mcx_pmem_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the execution unit: APB tasks and instruction scenarios.
`timescale 1ns/1ps
`default_nettype none
`include "mcx_consts.svh"
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        wdt_timeout_evt;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        instr_done;
  logic        halt_req;
  logic        halt_seen;
  logic        errv;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic [15:0] pmem_addr;
  logic [15:0] pmem_rdata;
  int          n_errors;
  int          checked;
  // Operations that must leave every flag alone, and operations only timed here.
  mcx_pkg::mcx_op_t keep_ops [8] = '{mcx_pkg::OP_RR, mcx_pkg::OP_RL, mcx_pkg::OP_MOV,
    mcx_pkg::OP_CLRB, mcx_pkg::OP_SETB, mcx_pkg::OP_CLRM, mcx_pkg::OP_SETM, mcx_pkg::OP_SWAP};
  mcx_pkg::mcx_op_t time_ops [7] = '{mcx_pkg::OP_AND, mcx_pkg::OP_OR, mcx_pkg::OP_XOR,
    mcx_pkg::OP_CPL, mcx_pkg::OP_INC, mcx_pkg::OP_DEC, mcx_pkg::OP_RRC};

  mcx_exec dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .wdt_timeout_evt(wdt_timeout_evt),
    .busy(busy), .instr_done(instr_done), .halt_req(halt_req)
  );

  // Sticky record of the one-cycle halt pulse, so a later check cannot miss it.
  always @(posedge pclk)
  begin
    if (halt_req === 1'b1)
      halt_seen <= 1'b1;
  end
  mcx_pmem_model pmem (.pclk(pclk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  // Builds an instruction word in the layout of the INSTR register.
  function automatic logic [31:0] mk(input mcx_pkg::mcx_op_t op, input logic ext,
    input logic tm, input logic ui, input logic [7:0] imm, input logic [8:0] ad);
    return {6'h00, ad, imm, ui, tm, ext, op};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic setm(input logic [8:0] a, input logic [7:0] v);
    apb(1'b1, `MCX_A_MADDR, {23'h0, a});
    apb(1'b1, `MCX_A_MDATA, {24'h0, v});
  endtask

  task automatic chkm(input logic [8:0] a, input logic [7:0] exp);
    apb(1'b1, `MCX_A_MADDR, {23'h0, a});
    rdc(`MCX_A_MDATA, {24'h0, exp});
  endtask

  // Starts an instruction and counts the cycles for which busy stands; done follows it.
  task automatic run(input logic [31:0] ins, input logic [31:0] n_exp);
    int k;
    apb(1'b1, `MCX_A_INSTR, ins);
    for (k = 0; k < 20; k++)
    begin
      #1;
      if (busy !== 1'b1) break;
      @(posedge pclk);
    end
    chk(32'(k), n_exp);
    chk({31'h0, instr_done}, 32'h1);
  endtask

  // Main sequence; each group ends with one line of progress.
  initial
  begin
    logic [7:0]  ptr;
    logic [15:0] exp;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wdt_timeout_evt = 1'b0;
    halt_seen = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`MCX_A_ACC, 32'h0);
    rdc(`MCX_A_FLAGS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, errv}, 32'h1);
    $display("test reset_and_unmapped done");
    setm(9'h050, 8'h01);
    setm(9'h150, 8'h88);
    apb(1'b1, `MCX_A_ACC, 32'h78);
    run(mk(mcx_pkg::OP_ADD, 1'b1, 1'b0, 1'b0, 8'h00, 9'h150), 32'h2);
    rdc(`MCX_A_ACC, 32'h0);
    rdc(`MCX_A_FLAGS, 32'h07);
    apb(1'b1, `MCX_A_ACC, 32'h3f);
    setm(9'h151, 8'h40);
    run(mk(mcx_pkg::OP_ADC, 1'b1, 1'b1, 1'b0, 8'h00, 9'h151), 32'h2);
    chkm(9'h151, 8'h80);
    rdc(`MCX_A_FLAGS, 32'h0a);
    run(mk(mcx_pkg::OP_ADD, 1'b0, 1'b0, 1'b1, 8'h01, 9'h000), 32'h1);
    rdc(`MCX_A_ACC, 32'h40);
    rdc(`MCX_A_FLAGS, 32'h02);
    apb(1'b1, `MCX_A_FLAGS, 32'h1e);
    run(mk(mcx_pkg::OP_AND, 1'b0, 1'b0, 1'b1, 8'h0f, 9'h000), 32'h1);
    rdc(`MCX_A_FLAGS, 32'h1f);
    $display("test add_and done");
    apb(1'b1, `MCX_A_FLAGS, 32'h00);
    apb(1'b1, `MCX_A_ACC, 32'h05);
    setm(9'h152, 8'h05);
    run(mk(mcx_pkg::OP_SUB, 1'b1, 1'b0, 1'b0, 8'h00, 9'h152), 32'h2);
    rdc(`MCX_A_FLAGS, 32'h27);
    apb(1'b1, `MCX_A_FLAGS, 32'h00);
    apb(1'b1, `MCX_A_ACC, 32'ha0);
    run(mk(mcx_pkg::OP_DAA, 1'b1, 1'b1, 1'b0, 8'h00, 9'h152), 32'h2);
    chkm(9'h152, 8'h00);
    rdc(`MCX_A_FLAGS, 32'h04);
    setm(9'h153, 8'h80);
    run(mk(mcx_pkg::OP_RLC, 1'b1, 1'b1, 1'b0, 8'h00, 9'h153), 32'h2);
    chkm(9'h153, 8'h01);
    rdc(`MCX_A_FLAGS, 32'h04);
    apb(1'b1, `MCX_A_FLAGS, 32'h1e);
    setm(9'h153, 8'hff);
    run(mk(mcx_pkg::OP_INC, 1'b1, 1'b0, 1'b0, 8'h00, 9'h153), 32'h2);
    rdc(`MCX_A_FLAGS, 32'h1f);
    chkm(9'h153, 8'hff);
    $display("test ext_arith done");
    apb(1'b1, `MCX_A_FLAGS, 32'h1e);
    foreach (keep_ops[i])
    begin
      run(mk(keep_ops[i], 1'b1, 1'b1, 1'b0, 8'h03, 9'h155), 32'h2);
      rdc(`MCX_A_FLAGS, 32'h1e);
    end
    foreach (time_ops[i])
      run(mk(time_ops[i], 1'b1, 1'b1, 1'b0, 8'h00, 9'h155), 32'h2);
    setm(9'h156, 8'h12);
    run(mk(mcx_pkg::OP_SWAP, 1'b1, 1'b0, 1'b0, 8'h00, 9'h156), 32'h2);
    rdc(`MCX_A_ACC, 32'h21);
    chkm(9'h156, 8'h12);
    $display("test ext_timing done");
    for (int e = 0; e < 2; e++)
      for (int z = 0; z < 2; z++)
      begin
        setm({e[0], 8'h53}, z[0] ? 8'h00 : 8'h5a);
        run(mk(mcx_pkg::OP_SZ, e[0], 1'b1, 1'b0, 8'h00, {e[0], 8'h53}),
            e[0] ? (z[0] ? 32'h4 : 32'h2) : (z[0] ? 32'h3 : 32'h1));
      end
    run(mk(mcx_pkg::OP_MOV, 1'b0, 1'b1, 1'b0, 8'h00, `MCX_PC_LO_ADDR), 32'h2);
    run(mk(mcx_pkg::OP_MOV, 1'b1, 1'b1, 1'b0, 8'h00, `MCX_PC_LO_ADDR), 32'h3);
    $display("test skip_pcl done");
    apb(1'b1, `MCX_A_TAB_PTR, 32'h0210);
    ptr = 8'h10;
    for (int v = 0; v < 4; v++)
    begin
      if (v[1])
        ptr = ptr + 8'h01;
      exp = {v[0] ? `MCX_LAST_PAGE : 8'h02, ptr} ^ 16'ha5c3;
      run(mk(mcx_pkg::OP_TAB, 1'b1, 1'b1, 1'b0, {6'h0, v[1:0]}, 9'h154), 32'h3);
      rdc(`MCX_A_TAB_HI, {24'h0, exp[15:8]});
      chkm(9'h154, exp[7:0]);
    end
    rdc(`MCX_A_TAB_PTR, {16'h0, 8'h02, ptr});
    $display("test table_read done");
    apb(1'b1, `MCX_A_FLAGS, 32'hc1);
    run(mk(mcx_pkg::OP_NOP, 1'b0, 1'b0, 1'b0, 8'h00, 9'h000), 32'h1);
    rdc(`MCX_A_FLAGS, 32'hc1);
    run(mk(mcx_pkg::OP_CLRWDT, 1'b0, 1'b0, 1'b0, 8'h00, 9'h000), 32'h1);
    rdc(`MCX_A_FLAGS, 32'h01);
    @(posedge pclk);
    wdt_timeout_evt <= 1'b1;
    @(posedge pclk);
    wdt_timeout_evt <= 1'b0;
    rdc(`MCX_A_FLAGS, 32'h41);
    chk({31'h0, halt_seen}, 32'h0);
    run(mk(mcx_pkg::OP_HALT, 1'b0, 1'b0, 1'b0, 8'h00, 9'h000), 32'h1);
    rdc(`MCX_A_FLAGS, 32'h81);
    chk({31'h0, halt_seen}, 32'h1);
    $display("test watchdog_flags done");
    apb(1'b1, `MCX_A_ACC, 32'h11);
    setm(9'h153, 8'h00);
    apb(1'b1, `MCX_A_INSTR, mk(mcx_pkg::OP_SZ, 1'b1, 1'b1, 1'b0, 8'h00, 9'h153));
    apb(1'b1, `MCX_A_ACC, 32'h77);
    chk({31'h0, errv}, 32'h1);
    repeat (8) @(posedge pclk);
    rdc(`MCX_A_ACC, 32'h11);
    $display("test busy_refusal done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
